// ### hdl/tmo_pkg.sv
// Constants, register map and types for the sixteen-bit timer with compare time base.
// Summary of operation
// - Sleep counting only in unsynchronised external mode.
// - Overflow wakes when run, enable, gate set.
// - After wake, branch to 0004h if global enable.
// - Capture copies full count into compare pair.
// - Compare event when compare pair equals count.
// - Special event clears both count bytes.
// - Special event clear never sets overflow flag.
// - Compare pair acts as timer period in special event mode.
// - Count write wins over simultaneous special clear.
// - Prescale codes divide by 1, 2, 4, 8.
// - Bit 3 enables low-power oscillator.
// - Bit 2 set leaves external clock unsynchronised.
// - Internal source ignores the synchronisation bit.
// - Bit 1 selects external pin or instruction clock.
// - Bit 0 runs or stops the timer.
// - Bits 7-6 read zero; implemented bits reset zero.
// - Count byte write clears hidden prescale counter.
// - Rollover FFFFh to 0000h sets overflow flag.
package tmo_pkg;

  localparam int          AXI_AW          = 8;
  localparam int          AXI_DW          = 32;

  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT_LOW   = 8'h04;
  localparam logic [7:0]  OFS_COUNT_HIGH  = 8'h08;
  localparam logic [7:0]  OFS_CMP_LOW     = 8'h0c;
  localparam logic [7:0]  OFS_CMP_HIGH    = 8'h10;
  localparam logic [7:0]  OFS_UNIT_MODE   = 8'h14;
  localparam logic [7:0]  OFS_IRQ_FLAGS   = 8'h18;
  localparam logic [7:0]  OFS_IRQ_ENABLES = 8'h1c;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Control register fields.
  localparam int          CTL_RUN         = 0;
  localparam int          CTL_SRC         = 1;
  localparam int          CTL_NOSYNC      = 2;
  localparam int          CTL_OSC         = 3;
  localparam int          CTL_PS_LO       = 4;
  localparam int          CTL_PS_HI       = 5;
  localparam int          CTL_BITS        = 6;
  localparam logic [5:0]  CTL_RESET       = 6'h00;

  // Interrupt flag and enable fields.
  localparam int          FLG_OVERFLOW    = 0;
  localparam int          FLG_COMPARE     = 1;
  localparam int          EN_OVERFLOW     = 0;
  localparam int          EN_PERIPH_GATE  = 1;
  localparam int          EN_GLOBAL       = 2;

  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [12:0] VECTOR_ADDR     = 13'h0004;
  localparam int          PRESC_W         = 3;

  typedef enum logic [1:0] {
    TMO_UNIT_OFF     = 2'b00,
    TMO_UNIT_CAPTURE = 2'b01,
    TMO_UNIT_COMPARE = 2'b10,
    TMO_UNIT_SPECIAL = 2'b11
  } tmo_unit_mode_e;

endpackage : tmo_pkg

// ### hdl/tmo_cmp_if.sv
// Carrier between the timer core and the compare detector.
`timescale 1ns/100ps
interface tmo_cmp_if;
  logic [15:0] count;
  logic [15:0] cmp_value;
  logic        compare_en;
  logic        match_pulse;

  modport timer (output count, output cmp_value, output compare_en, input match_pulse);
  modport cmp   (input count, input cmp_value, input compare_en, output match_pulse);
endinterface : tmo_cmp_if

// ### hdl/tmo_prescaler.sv
// Hidden prescale counter dividing the selected count clock by 1, 2, 4 or 8.
`timescale 1ns/100ps
module tmo_prescaler
  import tmo_pkg::*;
#(
  parameter int W = PRESC_W
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] select,
  output logic            step
);
  logic [W-1:0] cnt;
  logic [W-1:0] limit;

  assign limit = W'((1 << select) - 1);
  assign step  = tick_in && (cnt == limit) && !clear;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || step) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= W'(cnt + 1'b1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_presc_write_clear: assert property (clear |=> cnt == '0)
    else $error("Prescale counter not cleared by count write.");
  // Ticks may be sparse on the pin path, so only a tick arriving while the count differs from the limit is checked to advance it by one.
  chk_presc_divide: assert property (tick_in && !clear && cnt != limit
                                     |=> cnt == W'($past(cnt) + 1'b1))
    else $error("Prescale step came at the wrong division.");
endmodule : tmo_prescaler

// ### hdl/tmo_compare.sv
// Compare detector producing one pulse for each new equality of count and compare pair.
`timescale 1ns/100ps
module tmo_compare (
  input wire logic aclk,
  input wire logic aresetn,
  tmo_cmp_if.cmp   bus
);
  logic equal_now;
  logic equal_prev;

  assign equal_now       = bus.compare_en && (bus.count == bus.cmp_value);
  // Edge of equality, so a count frozen on the match yields one pulse only.
  assign bus.match_pulse = equal_now && !equal_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      equal_prev <= 1'b0;
    end else begin
      equal_prev <= equal_now;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_match_single: assert property (bus.match_pulse |=> !bus.match_pulse)
    else $error("Compare match pulse lasted more than one cycle.");
  chk_match_cause: assert property (bus.match_pulse |-> bus.count == bus.cmp_value)
    else $error("Compare pulse without equal values.");
endmodule : tmo_compare

// ### hdl/tmo_timer_top.sv
// Sixteen-bit timer with control register, sleep wake and compare time base, on AXI4-Lite.
`timescale 1ns/100ps
module tmo_timer_top
  import tmo_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_count_clock_pin,
  input  wire logic              capture_event,
  input  wire logic              core_sleeping,
  output logic                   low_power_osc_enable,
  output logic                   special_event,
  output logic                   core_irq_request,
  output logic                   wake_request,
  output logic                   branch_vector,
  output logic [12:0]            vector_addr
);
  logic [CTL_BITS-1:0] timer_one_control;
  logic [15:0]         count;
  logic [15:0]         cmp_value;
  tmo_unit_mode_e      unit_mode;
  logic                overflow_irq_flag;
  logic                compare_irq_flag;
  logic                overflow_irq_enable;
  logic                peripheral_irq_gate;
  logic                global_irq_enable;

  logic [AXI_AW-1:0]   aw_addr;
  logic [AXI_DW-1:0]   w_data;
  logic [3:0]          w_strb;
  logic                aw_full;
  logic                w_full;
  logic                wr_fire;
  logic                wr_lane0;
  logic                wr_ok;

  logic                ext_s1;
  logic                ext_s2;
  logic                ext_s3;
  logic                ext_raw;
  logic                ext_raw_d;
  logic                tick_in;
  logic                step;
  logic                inc;
  logic                cnt_wr;
  logic                se_clear;
  logic                rollover;

  tmo_cmp_if cmp_bus ();

  // Ready flags are the flops themselves, so the bus sees no gate on its ready lines.
  assign aw_full = !s_axi_awready;
  assign w_full  = !s_axi_wready;

  // Write address and data are latched independently and commit together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_fire  = aw_full && w_full && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];

  always_comb begin
    unique case (aw_addr)
      OFS_CONTROL, OFS_COUNT_LOW, OFS_COUNT_HIGH, OFS_CMP_LOW, OFS_CMP_HIGH,
      OFS_UNIT_MODE, OFS_IRQ_FLAGS, OFS_IRQ_ENABLES: wr_ok = 1'b1;
      default:                                     wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CONTROL:     s_axi_rdata <= AXI_DW'(timer_one_control);
        OFS_COUNT_LOW:   s_axi_rdata <= AXI_DW'(count[7:0]);
        OFS_COUNT_HIGH:  s_axi_rdata <= AXI_DW'(count[15:8]);
        OFS_CMP_LOW:     s_axi_rdata <= AXI_DW'(cmp_value[7:0]);
        OFS_CMP_HIGH:    s_axi_rdata <= AXI_DW'(cmp_value[15:8]);
        OFS_UNIT_MODE:   s_axi_rdata <= AXI_DW'(unit_mode);
        OFS_IRQ_FLAGS:   s_axi_rdata <= AXI_DW'({compare_irq_flag, overflow_irq_flag});
        OFS_IRQ_ENABLES: s_axi_rdata <= AXI_DW'({global_irq_enable, peripheral_irq_gate,
                                                 overflow_irq_enable});
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Only six bits exist; the top two are never stored and read back zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_one_control <= CTL_RESET;
    end else if (wr_lane0 && aw_addr == OFS_CONTROL) begin
      timer_one_control <= w_data[CTL_BITS-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_mode           <= TMO_UNIT_OFF;
      overflow_irq_enable <= 1'b0;
      peripheral_irq_gate <= 1'b0;
      global_irq_enable   <= 1'b0;
    end else if (wr_lane0 && aw_addr == OFS_UNIT_MODE) begin
      unit_mode <= tmo_unit_mode_e'(w_data[1:0]);
    end else if (wr_lane0 && aw_addr == OFS_IRQ_ENABLES) begin
      overflow_irq_enable <= w_data[EN_OVERFLOW];
      peripheral_irq_gate <= w_data[EN_PERIPH_GATE];
      global_irq_enable   <= w_data[EN_GLOBAL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power_osc_enable <= 1'b0;
    end else begin
      low_power_osc_enable <= timer_one_control[CTL_OSC];
    end
  end

  // Two-stage synchroniser for the synchronised path; a single sample for the other.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      ext_s3    <= 1'b0;
      ext_raw   <= 1'b0;
      ext_raw_d <= 1'b0;
    end else begin
      ext_s1    <= ext_count_clock_pin;
      ext_s2    <= ext_s1;
      ext_s3    <= ext_s2;
      ext_raw   <= ext_count_clock_pin;
      ext_raw_d <= ext_raw;
    end
  end

  always_comb begin
    if (!timer_one_control[CTL_SRC]) begin
      tick_in = !core_sleeping;
    end else if (timer_one_control[CTL_NOSYNC]) begin
      tick_in = ext_raw && !ext_raw_d;
    end else begin
      tick_in = ext_s2 && !ext_s3 && !core_sleeping;
    end
  end

  assign cnt_wr = wr_lane0 && (aw_addr == OFS_COUNT_LOW || aw_addr == OFS_COUNT_HIGH);

  tmo_prescaler #(
    .W       (PRESC_W)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (cnt_wr),
    .tick_in (tick_in && timer_one_control[CTL_RUN]),
    .select  (timer_one_control[CTL_PS_HI:CTL_PS_LO]),
    .step    (step)
  );

  assign inc      = step && timer_one_control[CTL_RUN];
  assign se_clear = cmp_bus.match_pulse && unit_mode == TMO_UNIT_SPECIAL;
  assign rollover = inc && !cnt_wr && !se_clear && count == COUNT_MAX;

  // Priority: software write, then special clear, then increment.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= COUNT_ZERO;
    end else if (cnt_wr) begin
      if (aw_addr == OFS_COUNT_LOW) begin
        count[7:0] <= w_data[7:0];
      end else begin
        count[15:8] <= w_data[7:0];
      end
    end else if (se_clear) begin
      count <= COUNT_ZERO;
    end else if (inc) begin
      count <= 16'(count + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_value <= COUNT_ZERO;
    end else if (unit_mode == TMO_UNIT_CAPTURE && capture_event) begin
      cmp_value <= count;
    end else if (wr_lane0 && aw_addr == OFS_CMP_LOW) begin
      cmp_value[7:0] <= w_data[7:0];
    end else if (wr_lane0 && aw_addr == OFS_CMP_HIGH) begin
      cmp_value[15:8] <= w_data[7:0];
    end
  end

  assign cmp_bus.count      = count;
  assign cmp_bus.cmp_value  = cmp_value;
  assign cmp_bus.compare_en = unit_mode == TMO_UNIT_COMPARE || unit_mode == TMO_UNIT_SPECIAL;

  tmo_compare u_compare (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (cmp_bus)
  );

  // Flags are cleared by writing ones; a new event in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_irq_flag <= 1'b0;
      compare_irq_flag  <= 1'b0;
    end else begin
      if (rollover) begin
        overflow_irq_flag <= 1'b1;
      end else if (wr_lane0 && aw_addr == OFS_IRQ_FLAGS && w_data[FLG_OVERFLOW]) begin
        overflow_irq_flag <= 1'b0;
      end
      if (cmp_bus.match_pulse) begin
        compare_irq_flag <= 1'b1;
      end else if (wr_lane0 && aw_addr == OFS_IRQ_FLAGS && w_data[FLG_COMPARE]) begin
        compare_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      special_event <= 1'b0;
    end else begin
      special_event <= se_clear;
    end
  end

  // Wake needs no global enable; the vector branch follows only if it is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_request     <= 1'b0;
      branch_vector    <= 1'b0;
      core_irq_request <= 1'b0;
      vector_addr      <= VECTOR_ADDR;
    end else begin
      wake_request     <= core_sleeping && rollover && timer_one_control[CTL_RUN]
                          && overflow_irq_enable && peripheral_irq_gate;
      branch_vector    <= wake_request && global_irq_enable;
      core_irq_request <= overflow_irq_flag && overflow_irq_enable && peripheral_irq_gate
                          && global_irq_enable;
      vector_addr      <= VECTOR_ADDR;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_overflow_flag: assert property (rollover |=> overflow_irq_flag && count == COUNT_ZERO)
    else $error("Rollover did not set the flag and wrap to zero.");
  chk_special_clear: assert property (se_clear && !cnt_wr |=> count == COUNT_ZERO)
    else $error("Special event did not clear the count.");
  chk_special_noflag: assert property (se_clear && !overflow_irq_flag |=> !overflow_irq_flag)
    else $error("Special event clear set the overflow flag.");
  chk_write_wins: assert property (cnt_wr && se_clear && aw_addr == OFS_COUNT_LOW
                                   |=> count[7:0] == $past(w_data[7:0]))
    else $error("Special clear overrode a count write.");
  chk_sleep_freeze: assert property (core_sleeping && !cnt_wr && !se_clear
      && !(timer_one_control[CTL_SRC] && timer_one_control[CTL_NOSYNC]) |=> $stable(count))
    else $error("Count advanced during sleep in a synchronised mode.");
  chk_stop_hold: assert property (!timer_one_control[CTL_RUN] && !cnt_wr && !se_clear
                                  |=> $stable(count))
    else $error("Stopped timer changed its count.");
  chk_capture_copy: assert property (unit_mode == TMO_UNIT_CAPTURE && capture_event
                                     |=> cmp_value == $past(count))
    else $error("Capture did not copy the count.");
  chk_wake_then_branch: assert property (wake_request && global_irq_enable
                                         |=> branch_vector && vector_addr == VECTOR_ADDR)
    else $error("Wake with global enable did not branch to the vector.");
  chk_wake_cause: assert property (core_sleeping && rollover && timer_one_control[CTL_RUN]
      && overflow_irq_enable && peripheral_irq_gate |=> wake_request)
    else $error("Overflow in sleep failed to wake the core.");
  chk_internal_ignore: assert property (!timer_one_control[CTL_SRC] && !core_sleeping
      && timer_one_control[CTL_RUN] && timer_one_control[CTL_PS_HI:CTL_PS_LO] == 2'h0
      && !cnt_wr && !se_clear |=> count == 16'($past(count) + 1'b1))
    else $error("Internal clock did not advance the count each cycle.");

  cov_rollover: cover property (rollover);
  cov_special: cover property (se_clear ##1 special_event);
  cov_wake_branch: cover property (wake_request ##1 branch_vector);
  cov_capture: cover property (unit_mode == TMO_UNIT_CAPTURE && capture_event);
endmodule : tmo_timer_top

// ### tb/tmo_partner.sv
// Far side model: external count clock source, capture strobe and core sleep level.
`timescale 1ns/100ps
module tmo_partner (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_on,
  input  wire logic sleep_on,
  input  wire logic cap_req,
  output logic      ext_count_clock_pin,
  output logic      capture_event,
  output logic      core_sleeping
);
  logic tog;

  // The pin clock stands low while no counting is wanted, like a gated source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog                 <= 1'b0;
      ext_count_clock_pin <= 1'b0;
    end else begin
      tog <= ~tog;
      if (!ext_on)
        ext_count_clock_pin <= 1'b0;
      else if (tog)
        ext_count_clock_pin <= ~ext_count_clock_pin;
    end
  end

  always_ff @(posedge aclk) begin
    capture_event <= aresetn & cap_req;
    core_sleeping <= aresetn & sleep_on;
  end
endmodule : tmo_partner

// ### tb/test_timer1_sleep_compare_time_base.sv
// Self-checking bench for the timer with sleep wake and compare time base.
`timescale 1ns/100ps
module test_timer1_sleep_compare_time_base;
  import tmo_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, wr_resp;
  logic        pin, cap, slp, lpo, spev, irq, wake, brv;
  logic [12:0] vaddr;
  logic        ext_on, sleep_on, cap_req;
  int          mismatches, check_count;

  tmo_timer_top tmo_timer_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_count_clock_pin(pin), .capture_event(cap),
    .core_sleeping(slp), .low_power_osc_enable(lpo), .special_event(spev),
    .core_irq_request(irq), .wake_request(wake), .branch_vector(brv),
    .vector_addr(vaddr));

  tmo_partner tmo_partner_inst (.aclk(aclk), .aresetn(aresetn), .ext_on(ext_on),
    .sleep_on(sleep_on), .cap_req(cap_req), .ext_count_clock_pin(pin),
    .capture_event(cap), .core_sleeping(slp));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // Each bus task lets one edge pass at its end, so no strobe is set twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
    wr(OFS_COUNT_LOW, {24'h0, lo});
    wr(OFS_COUNT_HIGH, {24'h0, hi});
  endtask : set_count

  task automatic t_registers;
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFS_CONTROL, d, r);
    check("control reset", d, 32'h0);
    wr(OFS_CONTROL, 32'hff);
    check("write resp", {30'h0, wr_resp}, {30'h0, RESP_OKAY});
    rd(OFS_CONTROL, d, r);
    check("control bits", d, 32'h3f);
    check("osc enable", {31'h0, lpo}, 32'h1);
    wr(OFS_CONTROL, 32'h0);
    check("osc disable", {31'h0, lpo}, 32'h0);
    rd(8'h20, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h20, 32'h0);
    check("unmapped write resp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    $display("test registers done");
  endtask : t_registers

  // Bit 2 is set on purpose: with the internal source it must change nothing.
  task automatic t_prescale;
    logic [31:0] c;
    logic [1:0]  r;
    int          lo;
    for (int p = 0; p < 4; p++) begin
      set_count(8'h0, 8'h0);
      wr(OFS_CONTROL, 32'(p << 4) | 32'h5);
      repeat (64) @(posedge aclk);
      wr(OFS_CONTROL, 32'h0);
      rd(OFS_COUNT_LOW, c, r);
      lo = 64 >> p;
      check("prescaled count", {31'h0, c >= lo && c <= lo + (8 >> p) + 1}, 32'h1);
    end
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_external;
    logic [31:0] c;
    logic [1:0]  r;
    set_count(8'h0, 8'h0);
    wr(OFS_CONTROL, 32'h3);
    ext_on <= 1'b1;
    repeat (80) @(posedge aclk);
    ext_on <= 1'b0;
    repeat (8) @(posedge aclk);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT_LOW, c, r);
    check("pin edge count", {31'h0, c >= 18 && c <= 21}, 32'h1);
    $display("test external done");
  endtask : t_external

  task automatic t_sleep;
    logic [31:0] c;
    logic [1:0]  r;
    logic        seen;
    seen = 1'b0;
    sleep_on <= 1'b1;
    set_count(8'h0, 8'h0);
    wr(OFS_CONTROL, 32'h1);
    repeat (40) @(posedge aclk);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT_LOW, c, r);
    check("frozen in sleep", c, 32'h0);
    set_count(8'hff, 8'hfe);
    wr(OFS_IRQ_ENABLES, 32'h7);
    wr(OFS_CONTROL, 32'h7);
    ext_on <= 1'b1;
    for (int n = 0; n < 200 && !seen; n++) begin
      @(posedge aclk);
      seen = (wake === 1'b1);
    end
    check("wake on overflow", {31'h0, seen}, 32'h1);
    @(posedge aclk);
    check("branch after wake", {31'h0, brv}, 32'h1);
    check("vector", {19'h0, vaddr}, 32'h0004);
    ext_on   <= 1'b0;
    sleep_on <= 1'b0;
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_IRQ_FLAGS, c, r);
    check("overflow flag", c & 32'h1, 32'h1);
    check("irq request", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_FLAGS, 32'h3);
    wr(OFS_IRQ_ENABLES, 32'h0);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_special;
    logic [31:0] c;
    logic [1:0]  r;
    int          n;
    wr(OFS_CMP_LOW, 32'h10);
    wr(OFS_CMP_HIGH, 32'h0);
    wr(OFS_UNIT_MODE, 32'h3);
    set_count(8'h0, 8'h0);
    wr(OFS_CONTROL, 32'h1);
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (spev === 1'b1) break;
    end
    for (n = 1; n < 100; n++) begin
      @(posedge aclk);
      if (spev === 1'b1) break;
    end
    check("special period", 32'(n), 32'd17);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_IRQ_FLAGS, c, r);
    check("flags after match", c & 32'h3, 32'h2);
    wr(OFS_IRQ_FLAGS, 32'h3);
    // Plain compare: the match raises the flag but the count runs on past it.
    set_count(8'h0, 8'h0);
    wr(OFS_UNIT_MODE, 32'h2);
    wr(OFS_CONTROL, 32'h1);
    repeat (40) @(posedge aclk);
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT_LOW, c, r);
    check("compare keeps count", c, 32'd44);
    rd(OFS_IRQ_FLAGS, c, r);
    check("compare flag only", c & 32'h3, 32'h2);
    wr(OFS_IRQ_FLAGS, 32'h3);
    wr(OFS_UNIT_MODE, 32'h0);
    $display("test special done");
  endtask : t_special

  task automatic t_capture;
    logic [31:0] c;
    logic [1:0]  r;
    wr(OFS_UNIT_MODE, 32'h1);
    set_count(8'h12, 8'h34);
    cap_req <= 1'b1;
    @(posedge aclk);
    cap_req <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(OFS_CMP_LOW, c, r);
    check("captured low", c, 32'h34);
    rd(OFS_CMP_HIGH, c, r);
    check("captured high", c, 32'h12);
    wr(OFS_UNIT_MODE, 32'h0);
    $display("test capture done");
  endtask : t_capture

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    #(40 * 20000);
    mismatches++;
    give_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {ext_on, sleep_on, cap_req} = 3'h0;
    awaddr      = 8'h0;
    araddr      = 8'h0;
    wdata       = 32'h0;
    mismatches  = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_registers();
    t_prescale();
    t_external();
    t_sleep();
    t_special();
    t_capture();
    give_verdict();
  end
endmodule : test_timer1_sleep_compare_time_base
